/* File: pkg/abm_pkg.sv */
// Shared types and constants of the asynchronous bus-master cycle sequencer.
// Assumes one system clock; each bus half-clock state lasts one system clock.
`default_nettype none

package abm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and state figures
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam logic [3:0]  LP_S0         = 4'h0;
  localparam logic [3:0]  LP_S1         = 4'h1;
  localparam logic [3:0]  LP_S2         = 4'h2;
  localparam logic [3:0]  LP_S3         = 4'h3;
  localparam logic [3:0]  LP_S4         = 4'h4;
  localparam logic [3:0]  LP_S5         = 4'h5;
  localparam logic [3:0]  LP_S6         = 4'h6;
  localparam logic [3:0]  LP_S7         = 4'h7;
  localparam logic [3:0]  LP_S8         = 4'h8;
  localparam logic [3:0]  LP_S9         = 4'h9;
  localparam logic [3:0]  LP_S11        = 4'hb;
  localparam logic [7:0]  TAS_SET_MASK  = 8'h80;

  ////////////////////////////////////////////////////////////////////////////
  // Requests, answers and pins
  typedef enum logic [1:0] {ABM_OP_READ, ABM_OP_WRITE, ABM_OP_TAS} abm_op_e;
  typedef enum logic [1:0] {ABM_ST_OK, ABM_ST_FAULT, ABM_ST_LEGACY} abm_status_e;
  typedef enum logic [1:0] {ABM_IDLE, ABM_RUN, ABM_WAIT} abm_state_e;

  typedef struct packed {
    abm_op_e     op;
    logic        word;
    logic [2:0]  cycle_space_code;
    logic [23:0] addr;
    logic [15:0] wdata;
  } abm_req_s;

  typedef struct packed {
    abm_status_e status;
    logic [15:0] rdata;
    logic        tas_was_set;
  } abm_rsp_s;

  typedef struct packed {
    logic [2:0]  cycle_space_code;
    logic [23:0] addr;
    logic        addr_oe_n;
    logic [15:0] data_out;
    logic        data_oe_n;
    logic        rnw;
    logic        addr_strobe_n;
    logic        upper_byte_strobe_n;
    logic        lower_byte_strobe_n;
    logic        single_byte_strobe_n;
  } abm_pins_s;

  localparam abm_pins_s PINS_RESET = '{cycle_space_code: 3'h0, addr: 24'h0,
    addr_oe_n: 1'b1, data_out: 16'h0, data_oe_n: 1'b1, rnw: 1'b1,
    addr_strobe_n: 1'b1, upper_byte_strobe_n: 1'b1, lower_byte_strobe_n: 1'b1,
    single_byte_strobe_n: 1'b1};

  localparam logic [18:0] SYNC_RESET = 19'h70000;

endpackage

`default_nettype wire

/* File: core/abm_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk; output moves once stages two and three agree.
`default_nettype none

module abm_sync #(
  parameter int unsigned       W    = 1,
  parameter logic [W-1:0]      INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;

  ////////////////////////////////////////////////////////////////////////////
  // Stage one feeds stage two only
  always_comb
  begin
    nxt_out = ((s2_ff ~^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & out_ff);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_ff  <= INIT;
      s2_ff  <= INIT;
      s3_ff  <= INIT;
      out_ff <= INIT;
    end
    else
    begin
      s1_ff  <= din;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign dout = out_ff;

endmodule

`default_nettype wire

/* File: core/abm_master.sv */
// Bus-master cycle sequencer: read, write and test-and-set cycles on the async bus.
// Assumes slaves answer on the active-low inputs; bus_clk is the bus's own clock.
//
// Operation
// - 8-bit mode splits word writes into two byte cycles, address bit 0 picks byte
// - Write S0 drives function code and read high; address valid entering S1
// - Write S2 rising edge asserts address strobe and drives write
// - Write S3 drives write data onto the data bus
// - 8-bit write asserts lower and single strobes at S4, then awaits termination
// - No termination by end of S4 inserts whole-clock wait states
// - Legacy peripheral select during strobe wait converts cycle to legacy cycle
// - Write strobes negate entering S7; buses float and read high ending S7
// - Test-and-set is byte only; address strobe held through read and write
// - Test-and-set read latches data entering S7, negates byte strobes only unless faulted
// - Test-and-set S8 to S11 hold all bus signals unchanged
// - Test-and-set write starts S12 unchanged; write driven at S14
// - Test-and-set S15 drives the modified byte
// - Test-and-set S16 asserts strobe, waits with whole-clock wait states
// - Test-and-set strobes negate entering S19; buses float ending S19
// - 16-bit reads: word uses both strobes, byte picks strobe by address bit 0
// - Read S0 function code and read high; S2 asserts address and byte strobes
// - Read latches data and negates strobes entering S7, then floats address
// - Termination inputs sampled each bus clock from S4; data latched end of S6
// - Cycle ends in S7; fault without acknowledge extends one clock to S9
`default_nettype none

module abm_master (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              mode_8bit,
  input  wire logic              req_valid,
  input  wire abm_pkg::abm_req_s req,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output abm_pkg::abm_rsp_s      rsp,
  output logic                   bus_clk,
  output abm_pkg::abm_pins_s     pins,
  input  wire logic [15:0]       data_in,
  input  wire logic              transfer_ack_n,
  input  wire logic              bus_fault_n,
  input  wire logic              legacy_periph_select_n
);

  import abm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [2:0] strobe_set(input logic m8, input logic word,
                                            input logic a0);
    // Order: upper, lower, single; active low
    if (m8)
      strobe_set = 3'h4;
    else if (word)
      strobe_set = 3'h1;
    else if (a0)
      strobe_set = 3'h5;
    else
      strobe_set = 3'h3;
  endfunction

  function automatic logic [7:0] byte_lane(input logic [15:0] d, input logic m8,
                                           input logic a0);
    if (m8 || a0)
      byte_lane = d[7:0];
    else
      byte_lane = d[15:8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [18:0] sync_q;
  logic        ack_s;
  logic        fault_s;
  logic        legacy_s;
  logic [15:0] din_s;

  abm_sync #(
    .W    (19),
    .INIT (SYNC_RESET)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({transfer_ack_n, bus_fault_n, legacy_periph_select_n, data_in}),
    .dout (sync_q)
  );

  assign ack_s    = ~sync_q[18];
  assign fault_s  = ~sync_q[17];
  assign legacy_s = ~sync_q[16];
  assign din_s    = sync_q[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  abm_state_e  st_ff;
  abm_state_e  nxt_st;
  logic [3:0]  lp_ff;
  logic [3:0]  nxt_lp;
  abm_req_s    cur_ff;
  abm_req_s    nxt_cur;
  logic        m8_ff;
  logic        nxt_m8;
  logic        second_ff;
  logic        nxt_second;
  logic        a0_ff;
  logic        nxt_a0;
  logic        wrpart_ff;
  logic        nxt_wrpart;
  abm_status_e stat_ff;
  abm_status_e nxt_stat;
  logic [15:0] rd_ff;
  logic [15:0] nxt_rd;
  logic [7:0]  tas_ff;
  logic [7:0]  nxt_tas;
  abm_pins_s   pins_ff;
  abm_pins_s   nxt_pins;
  logic        bclk_ff;
  logic        ready_ff;
  logic        nxt_ready;
  logic        rsp_valid_ff;
  logic        nxt_rsp_valid;
  abm_rsp_s    rsp_ff;
  abm_rsp_s    nxt_rsp;
  logic        is_tas;
  logic        is_wr;
  logic        split;

  assign is_tas = (cur_ff.op == ABM_OP_TAS);
  assign is_wr  = (cur_ff.op == ABM_OP_WRITE) || (is_tas && wrpart_ff);
  assign split  = m8_ff && cur_ff.word && !is_tas;

  always_comb
  begin
    nxt_st        = st_ff;
    nxt_lp        = lp_ff;
    nxt_cur       = cur_ff;
    nxt_m8        = m8_ff;
    nxt_second    = second_ff;
    nxt_a0        = a0_ff;
    nxt_wrpart    = wrpart_ff;
    nxt_stat      = stat_ff;
    nxt_rd        = rd_ff;
    nxt_tas       = tas_ff;
    nxt_pins      = pins_ff;
    nxt_rsp       = rsp_ff;
    nxt_rsp_valid = 1'b0;
    case (st_ff)
      ABM_IDLE:
      begin
        if (req_valid && ready_ff)
        begin
          nxt_st                    = ABM_RUN;
          nxt_lp                    = LP_S0;
          nxt_cur                   = req;
          nxt_m8                    = mode_8bit;
          nxt_second                = 1'b0;
          nxt_a0                    = req.addr[0];
          nxt_wrpart                = 1'b0;
          nxt_stat                  = ABM_ST_OK;
          nxt_pins.cycle_space_code = req.cycle_space_code;
          nxt_pins.rnw              = 1'b1;
        end
      end
      ABM_WAIT:
      begin
        // First half of a whole-clock wait state
        nxt_st = ABM_RUN;
      end
      ABM_RUN:
      begin
        nxt_lp = lp_ff + 4'h1;
        case (lp_ff)
          LP_S0:
          begin
            nxt_pins.addr      = {cur_ff.addr[23:1], a0_ff};
            nxt_pins.addr_oe_n = 1'b0;
          end
          LP_S1:
          begin
            nxt_pins.addr_strobe_n = 1'b0;
            if (is_wr)
              nxt_pins.rnw = 1'b0;
            else
              {nxt_pins.upper_byte_strobe_n, nxt_pins.lower_byte_strobe_n,
               nxt_pins.single_byte_strobe_n} = strobe_set(m8_ff, cur_ff.word, a0_ff);
          end
          LP_S2:
          begin
            if (is_wr)
            begin
              nxt_pins.rnw       = 1'b0;
              nxt_pins.data_oe_n = 1'b0;
              if (is_tas)
                nxt_pins.data_out = {tas_ff | TAS_SET_MASK, tas_ff | TAS_SET_MASK};
              else if (m8_ff)
                nxt_pins.data_out = {8'h00, (cur_ff.word && !second_ff) ?
                                     cur_ff.wdata[15:8] : cur_ff.wdata[7:0]};
              else if (cur_ff.word)
                nxt_pins.data_out = cur_ff.wdata;
              else if (a0_ff)
                nxt_pins.data_out = {8'h00, cur_ff.wdata[7:0]};
              else
                nxt_pins.data_out = {cur_ff.wdata[7:0], 8'h00};
            end
          end
          LP_S3:
          begin
            if (is_wr)
              {nxt_pins.upper_byte_strobe_n, nxt_pins.lower_byte_strobe_n,
               nxt_pins.single_byte_strobe_n} = strobe_set(m8_ff, cur_ff.word, a0_ff);
          end
          LP_S4:
          begin
            // Acknowledge wins over fault, fault over legacy select
            if (ack_s)
              nxt_stat = ABM_ST_OK;
            else if (fault_s)
              nxt_stat = ABM_ST_FAULT;
            else if (legacy_s)
              nxt_stat = ABM_ST_LEGACY;
            else
            begin
              nxt_st = ABM_WAIT;
              nxt_lp = lp_ff;
            end
          end
          LP_S6:
          begin
            if (!is_wr)
            begin
              nxt_tas = byte_lane(din_s, m8_ff, a0_ff);
              if (!cur_ff.word)
                nxt_rd = {8'h00, byte_lane(din_s, m8_ff, a0_ff)};
              else if (split && !second_ff)
                nxt_rd = {din_s[7:0], rd_ff[7:0]};
              else if (split)
                nxt_rd = {rd_ff[15:8], din_s[7:0]};
              else
                nxt_rd = din_s;
            end
            nxt_pins.upper_byte_strobe_n  = 1'b1;
            nxt_pins.lower_byte_strobe_n  = 1'b1;
            nxt_pins.single_byte_strobe_n = 1'b1;
            // Read half of test-and-set keeps the address strobe unless faulted: cycle is indivisible
            if (!(is_tas && !wrpart_ff && stat_ff != ABM_ST_FAULT))
              nxt_pins.addr_strobe_n = 1'b1;
          end
          default:
          begin
            // S5 holds; S7 and beyond: end, fault extension or test-and-set hold
            if (lp_ff >= LP_S7 && (stat_ff == ABM_ST_FAULT || !is_tas || wrpart_ff))
            begin
              nxt_pins.addr_oe_n = 1'b1;
              nxt_pins.data_oe_n = 1'b1;
              nxt_pins.rnw       = 1'b1;
              if (stat_ff == ABM_ST_FAULT && lp_ff != LP_S9)
                nxt_lp = lp_ff + 4'h1;
              else if (split && !second_ff && stat_ff == ABM_ST_OK)
              begin
                nxt_second = 1'b1;
                nxt_a0     = 1'b1;
                nxt_lp     = LP_S0;
              end
              else
              begin
                nxt_st              = ABM_IDLE;
                nxt_rsp_valid       = 1'b1;
                nxt_rsp.status      = stat_ff;
                nxt_rsp.rdata       = rd_ff;
                nxt_rsp.tas_was_set = tas_ff[7];
              end
            end
            else if (lp_ff == LP_S11)
            begin
              nxt_wrpart = 1'b1;
              nxt_lp     = LP_S0;
            end
          end
        endcase
      end
      default:
      begin
        nxt_st = ABM_IDLE;
      end
    endcase
    // Requests are taken only while bus_clk is low so S0 opens on a rising edge
    nxt_ready = (nxt_st == ABM_IDLE) && bclk_ff;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff        <= ABM_IDLE;
      lp_ff        <= LP_S0;
      cur_ff       <= '0;
      m8_ff        <= 1'b0;
      second_ff    <= 1'b0;
      a0_ff        <= 1'b0;
      wrpart_ff    <= 1'b0;
      stat_ff      <= ABM_ST_OK;
      rd_ff        <= 16'h0;
      tas_ff       <= 8'h0;
      pins_ff      <= PINS_RESET;
      bclk_ff      <= 1'b0;
      ready_ff     <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_ff       <= '0;
    end
    else
    begin
      st_ff        <= nxt_st;
      lp_ff        <= nxt_lp;
      cur_ff       <= nxt_cur;
      m8_ff        <= nxt_m8;
      second_ff    <= nxt_second;
      a0_ff        <= nxt_a0;
      wrpart_ff    <= nxt_wrpart;
      stat_ff      <= nxt_stat;
      rd_ff        <= nxt_rd;
      tas_ff       <= nxt_tas;
      pins_ff      <= nxt_pins;
      bclk_ff      <= ~bclk_ff;
      ready_ff     <= nxt_ready;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_ff       <= nxt_rsp;
    end
  end

  assign req_ready = ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp       = rsp_ff;
  assign bus_clk   = bclk_ff;
  assign pins      = pins_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic run_mid;
  assign run_mid = (st_ff != ABM_IDLE) && lp_ff >= LP_S2 && lp_ff <= LP_S6;

  a_idle_quiet: assert property (
    st_ff == ABM_IDLE |-> pins_ff.addr_strobe_n && pins_ff.rnw &&
      pins_ff.lower_byte_strobe_n && pins_ff.upper_byte_strobe_n &&
      pins_ff.single_byte_strobe_n)
    else $error("strobes or read level wrong while idle");

  a_as_at_s2: assert property (
    st_ff == ABM_RUN && lp_ff == LP_S1 && !is_tas |=> !pins_ff.addr_strobe_n && lp_ff == LP_S2)
    else $error("address strobe not asserted at S2");

  a_write_low: assert property (
    run_mid && is_wr && lp_ff >= LP_S3 |-> !pins_ff.rnw && !pins_ff.data_oe_n)
    else $error("write data or direction missing");

  a_wstrobe_s4: assert property (
    run_mid && is_wr && m8_ff && lp_ff >= LP_S4 |->
      !pins_ff.lower_byte_strobe_n && !pins_ff.single_byte_strobe_n &&
      pins_ff.upper_byte_strobe_n)
    else $error("8-bit write strobe wrong");

  a_wait_whole: assert property (
    st_ff == ABM_WAIT |=> st_ff == ABM_RUN && lp_ff == LP_S4 && $stable(pins_ff))
    else $error("wait state not a whole bus clock");

  a_tas_hold: assert property (
    is_tas && !wrpart_ff && lp_ff >= LP_S8 && stat_ff == ABM_ST_OK |=>
      $stable(pins_ff) && !pins_ff.addr_strobe_n)
    else $error("bus changed during modify states");

  a_end_float: assert property (
    rsp_valid_ff |-> pins_ff.addr_oe_n && pins_ff.data_oe_n && pins_ff.rnw &&
      pins_ff.addr_strobe_n)
    else $error("bus not released at cycle end");

  a_fault_ext: assert property (
    st_ff == ABM_RUN && lp_ff == LP_S7 && stat_ff == ABM_ST_FAULT |=>
      lp_ff == LP_S8 ##1 lp_ff == LP_S9 ##1 rsp_valid_ff && rsp_ff.status == ABM_ST_FAULT)
    else $error("fault cycle not extended to S9");

  a_word_read: assert property (
    run_mid && !is_wr && !m8_ff && cur_ff.word |->
      !pins_ff.upper_byte_strobe_n && !pins_ff.lower_byte_strobe_n)
    else $error("word read missing a strobe");

  a_split_a0: assert property (
    st_ff == ABM_RUN && second_ff && lp_ff >= LP_S1 |-> pins_ff.addr[0])
    else $error("second byte cycle address bit wrong");

  a_tas_rnw_s14: assert property (
    st_ff == ABM_RUN && is_tas && wrpart_ff && lp_ff == LP_S2 |->
      !pins_ff.rnw && pins_ff.data_oe_n && !pins_ff.addr_strobe_n)
    else $error("write direction not set at S14");

  c_tas_done: cover property (rsp_valid_ff && is_tas && rsp_ff.status == ABM_ST_OK);
  c_fault: cover property (rsp_valid_ff && rsp_ff.status == ABM_ST_FAULT);
  c_wait: cover property (st_ff == ABM_WAIT ##2 st_ff == ABM_WAIT);
  c_split: cover property (rsp_valid_ff && split);

endmodule

`default_nettype wire

/* File: tb/abm_slave_model.sv */
// Slave model: byte memory answering with acknowledge, fault or legacy select.
// Assumes the master's pin struct; the bench picks the answer kind and its delay.
`default_nettype none

module abm_slave_model (
  input  wire logic               clk,
  input  wire logic               mode_8bit,
  input  wire abm_pkg::abm_pins_s pins,
  input  wire logic [7:0]         dly,
  input  wire logic [1:0]         resp,
  output logic [15:0]             data_in,
  output logic                    transfer_ack_n,
  output logic                    bus_fault_n,
  output logic                    legacy_periph_select_n,
  output logic [7:0]              n_as,
  output logic [7:0]              n_bs,
  output logic [4:0]              seen,
  output logic                    wr_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  import abm_pkg::*;

  logic [7:0]  mem [64];
  logic [7:0]  cnt;
  logic [15:0] junk;
  logic        act, act_q, as_q, hit;
  logic [5:0]  ev, od;

  ////////////////////////////////////////////////////////////////////////////
  assign act = !pins.addr_strobe_n
               && !(pins.upper_byte_strobe_n && pins.lower_byte_strobe_n);
  assign hit = act && cnt >= dly;
  // Answers drop as soon as the strobes negate
  assign transfer_ack_n         = !(hit && resp == 2'h0);
  assign bus_fault_n            = !(hit && resp == 2'h1);
  assign legacy_periph_select_n = !(hit && resp == 2'h2);
  assign ev = {pins.addr[5:1], 1'b0};
  assign od = {pins.addr[5:1], 1'b1};
  // Decoded from the address early; a released bus shows a moving pattern
  assign data_in = (pins.rnw && !pins.addr_oe_n)
                   ? (mode_8bit ? {junk[15:8], mem[pins.addr[5:0]]} : {mem[ev], mem[od]})
                   : junk;

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cnt = 8'h0;
    junk = 16'h5a3c;
    act_q = 1'b0;
    as_q = 1'b0;
    n_as = 8'h0;
    n_bs = 8'h0;
    seen = 5'h0;
    wr_ok = 1'b0;
  end

  always @(posedge clk)
  begin
    junk <= {junk[14:0], ~junk[15]};
    act_q <= act;
    as_q <= !pins.addr_strobe_n;
    cnt <= act ? ((cnt == 8'hff) ? cnt : cnt + 8'h1) : 8'h0;
    if (!pins.addr_strobe_n && !as_q)
      n_as <= n_as + 8'h1;
    if (act && !act_q)
    begin
      n_bs <= n_bs + 8'h1;
      seen <= {pins.cycle_space_code, pins.upper_byte_strobe_n, pins.lower_byte_strobe_n};
    end
    // Write lands when the acknowledge goes out
    if (act && cnt == dly && !pins.rnw && resp == 2'h0)
    begin
      wr_ok <= !pins.data_oe_n && !pins.addr_oe_n;
      if (mode_8bit)
        mem[pins.addr[5:0]] <= pins.data_out[7:0];
      else
      begin
        if (!pins.upper_byte_strobe_n)
          mem[ev] <= pins.data_out[15:8];
        if (!pins.lower_byte_strobe_n)
          mem[od] <= pins.data_out[7:0];
      end
    end
  end
endmodule

`default_nettype wire

/* File: tb/test_async_bus_master_cycles.sv */
// Self-checking bench for the bus-master sequencer against the slave model.
// Assumes abm_pkg types; expected answers are queued and matched in order.
`default_nettype none

module test_async_bus_master_cycles;
  timeunit 1ns;
  timeprecision 1ns;
  import abm_pkg::*;

  typedef struct packed {abm_rsp_s r; logic [16:0] m;} abm_exp_s;

  logic        clk, rst, mode_8bit, req_valid, req_ready, rsp_valid;
  logic        ack_n, fault_n, legacy_n, wr_ok, bus_clk;
  abm_req_s    req;
  abm_rsp_s    rsp;
  abm_pins_s   pins;
  logic [15:0] data_in, w0, w1;
  logic [7:0]  dly, n_as, n_bs, nb, na, b0;
  logic [1:0]  resp;
  logic [4:0]  seen;
  abm_exp_s    expq[$];
  int          err_count, num_checks, rsp_cnt, seed_v;

  abm_master dut (.clk(clk), .rst(rst), .mode_8bit(mode_8bit), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .bus_clk(bus_clk),
    .pins(pins), .data_in(data_in), .transfer_ack_n(ack_n), .bus_fault_n(fault_n),
    .legacy_periph_select_n(legacy_n));
  abm_slave_model slave (.clk(clk), .mode_8bit(mode_8bit), .pins(pins), .dly(dly),
    .resp(resp), .data_in(data_in), .transfer_ack_n(ack_n), .bus_fault_n(fault_n),
    .legacy_periph_select_n(legacy_n), .n_as(n_as), .n_bs(n_bs), .seen(seen), .wr_ok(wr_ok));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_rsp(input abm_exp_s e, input abm_rsp_s g);
    cmp_val("status", {14'h0, e.r.status}, {14'h0, g.status});
    cmp_val("rdata", e.r.rdata & e.m[15:0], g.rdata & e.m[15:0]);
    cmp_val("tas_was_set", {15'h0, e.r.tas_was_set & e.m[16]},
            {15'h0, g.tas_was_set & e.m[16]});
  endtask

  function automatic logic [15:0] idle_v();
    return {9'h0, pins.addr_strobe_n, pins.upper_byte_strobe_n, pins.lower_byte_strobe_n,
            pins.single_byte_strobe_n, pins.rnw, pins.addr_oe_n, pins.data_oe_n};
  endfunction

  // Request held until the taking edge, then the answer is awaited
  task automatic do_req(input abm_op_e op, input logic wd, input logic [23:0] a,
      input logic [15:0] wdat, input abm_status_e st, input logic [15:0] rd,
      input logic [16:0] m);
    int n;
    int i;
    n = rsp_cnt;
    i = 0;
    expq.push_back('{'{st, rd, rd[7]}, m});
    req <= '{op, wd, 3'($urandom), a, wdat};
    req_valid <= 1'b1;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (req_ready !== 1'b1 && i < 300);
    req_valid <= 1'b0;
    cmp_val("bus_clk_take", 16'h0, {15'h0, bus_clk});
    while (rsp_cnt == n && i < 300)
    begin
      @(posedge clk);
      i++;
    end
    if (i >= 300)
    begin
      err_count++;
      $display("ERROR response expected 1 seen 0");
      conclude();
    end
    cmp_val("fcode", {13'h0, req.cycle_space_code}, {13'h0, seen[4:2]});
    cmp_val("idle_pins", 16'h7f, idle_v());
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      rsp_cnt++;
      if (expq.size() == 0)
        cmp_val("rsp_extra", 16'h0, 16'h1);
      else
        cmp_rsp(expq.pop_front(), rsp);
    end
  end

  initial
  begin
    seed_v = $urandom(32'haca1d317);
    rst = 1'b1;
    mode_8bit = 1'b0;
    req_valid = 1'b0;
    req = '0;
    dly = 8'h0;
    resp = 2'h0;
    err_count = 0;
    num_checks = 0;
    rsp_cnt = 0;
    repeat (16) @(posedge clk);
    cmp_val("reset_pins", 16'h7f, idle_v());
    rst <= 1'b0;
    w0 = 16'($urandom);
    do_req(ABM_OP_WRITE, 1'b1, 24'h10, w0, ABM_ST_OK, 16'h0, 17'h0);
    cmp_val("wr_drive", 16'h1, {15'h0, wr_ok});
    do_req(ABM_OP_READ, 1'b1, 24'h10, 16'h0, ABM_ST_OK, w0, 17'hffff);
    cmp_val("lanes_word", 16'h0, {14'h0, seen[1:0]});
    do_req(ABM_OP_READ, 1'b0, 24'h10, 16'h0, ABM_ST_OK, {8'h0, w0[15:8]}, 17'hff);
    cmp_val("lanes_a0_0", 16'h1, {14'h0, seen[1:0]});
    do_req(ABM_OP_READ, 1'b0, 24'h11, 16'h0, ABM_ST_OK, {8'h0, w0[7:0]}, 17'hff);
    cmp_val("lanes_a0_1", 16'h2, {14'h0, seen[1:0]});
    $display("test bus16 done");
    // Split word on the 8-bit bus, read back on both widths
    mode_8bit <= 1'b1;
    w1 = 16'($urandom);
    nb = n_bs;
    na = n_as;
    do_req(ABM_OP_WRITE, 1'b1, 24'h20, w1, ABM_ST_OK, 16'h0, 17'h0);
    cmp_val("split_cycles", {8'h2, 8'h2}, {n_bs - nb, n_as - na});
    cmp_val("lanes_8bit", 16'h2, {14'h0, seen[1:0]});
    do_req(ABM_OP_READ, 1'b1, 24'h20, 16'h0, ABM_ST_OK, w1, 17'hffff);
    mode_8bit <= 1'b0;
    do_req(ABM_OP_READ, 1'b1, 24'h20, 16'h0, ABM_ST_OK, w1, 17'hffff);
    $display("test split8 done");
    // Slow slave forces wait states
    for (int i = 0; i < 3; i++)
    begin
      dly <= 8'(1 + $urandom % 30);
      w0 = 16'($urandom);
      do_req(ABM_OP_WRITE, 1'b1, 24'h08, w0, ABM_ST_OK, 16'h0, 17'h0);
      do_req(ABM_OP_READ, 1'b1, 24'h08, 16'h0, ABM_ST_OK, w0, 17'hffff);
    end
    dly <= 8'h0;
    $display("test waits done");
    // Fault and legacy select end cycles without a transfer
    for (int r = 1; r < 3; r++)
    begin
      resp <= 2'(r);
      do_req(ABM_OP_WRITE, 1'b1, 24'h20, ~w1, abm_status_e'(r), 16'h0, 17'h0);
      do_req(ABM_OP_READ, 1'b1, 24'h20, 16'h0, abm_status_e'(r), 16'h0, 17'h0);
    end
    mode_8bit <= 1'b1;
    resp <= 2'h1;
    nb = n_bs;
    do_req(ABM_OP_WRITE, 1'b1, 24'h20, ~w1, ABM_ST_FAULT, 16'h0, 17'h0);
    cmp_val("fault_split", 16'h1, {8'h0, n_bs - nb});
    resp <= 2'h0;
    do_req(ABM_OP_READ, 1'b1, 24'h20, 16'h0, ABM_ST_OK, w1, 17'hffff);
    $display("test abort done");
    // Test-and-set on both widths, second one with a slow slave in both halves
    for (int m = 0; m < 2; m++)
    begin
      b0 = {m[0], 7'($urandom)};
      do_req(ABM_OP_WRITE, 1'b0, 24'h31, {8'h0, b0}, ABM_ST_OK, 16'h0, 17'h0);
      mode_8bit <= !m[0];
      dly <= 8'(4 * m);
      nb = n_bs;
      na = n_as;
      do_req(ABM_OP_TAS, 1'b0, 24'h31, 16'h0, ABM_ST_OK, {8'h0, b0}, 17'h100ff);
      cmp_val("tas_strobes", {8'h1, 8'h2}, {n_as - na, n_bs - nb});
      cmp_val("tas_lanes", 16'h2, {14'h0, seen[1:0]});
      dly <= 8'h0;
      mode_8bit <= 1'b1;
      do_req(ABM_OP_READ, 1'b0, 24'h31, 16'h0, ABM_ST_OK, {8'h0, b0 | 8'h80}, 17'hff);
    end
    $display("test tas done");
    conclude();
  end
endmodule

`default_nettype wire
